/* rtl/bsp_defs.svh */
// timing constants and the ns-to-cycle conversion for the burst-of-two memory port
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH
`define BSP_LOCK_CYCLES 1024
`define BSP_DOFF_LOW_NS 5
`define BSP_KSTATIC_NS 30
`define BSP_SYS_MHZ 250
`define BSP_LINK_PS 15000
`define BSP_NS_TO_CYC(ns) (((ns) * `BSP_SYS_MHZ + 999) / 1000)
`endif

/* rtl/bsp_pkg.sv */
// types shared by the burst-of-two memory port
package bsp_pkg;
   typedef enum logic [1:0] {
      BSP_IDLE,
      BSP_READ,
      BSP_WRITE
   } bsp_cmd_t;
endpackage

/* rtl/bsp_port.sv */
// burst-of-two static memory port with lock tracking and forwarding
`timescale 1ns/1ps
`include "bsp_defs.svh"
module bsp_port #(
   parameter int ADDR_W = 6,
   parameter int BYTES = 2,
   parameter int LOCK_CYCLES = `BSP_LOCK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic dll_off_n,
   input wire logic out_clk_high,
   input wire logic rd_req_n,
   input wire logic wr_req_n,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [BYTES*8-1:0] wr_beat1,
   input wire logic [BYTES*8-1:0] wr_beat2,
   input wire logic [BYTES-1:0] byte_write_mask_n1,
   input wire logic [BYTES-1:0] byte_write_mask_n2,
   output logic [BYTES*8-1:0] rd_data,
   output logic rd_valid,
   output logic rd_data_oe_n,
   output logic echo_clock,
   output logic dll_locked,
   output logic ref_from_input
);
   import bsp_pkg::*;

   localparam int W = BYTES * 8;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int DOFF_CYC = `BSP_NS_TO_CYC(`BSP_DOFF_LOW_NS);
   localparam int KST_CYC = `BSP_NS_TO_CYC(`BSP_KSTATIC_NS);
   localparam int LK_W = $clog2(LOCK_CYCLES + 1);

   function automatic logic [W-1:0] merge(input logic [W-1:0] old_v,
      input logic [W-1:0] new_v, input logic [BYTES-1:0] m_n);
      logic [W-1:0] r;
      r = old_v;
      for (int i = 0; i < BYTES; i++)
      begin
         if (!m_n[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // link domain: lock counter on link clock
   // ==========================================================
   logic [LK_W-1:0] lk_cnt_reg;
   logic [LK_W-1:0] lk_cnt_next;
   logic lk_done_reg;
   logic lk_done_next;
   logic lk_tgl_reg;
   logic lk_tgl_next;
   logic [1:0] rst_s_reg;
   logic [1:0] rst_s_next;
   logic loop_rst;

   always_comb
   begin
      rst_s_next = {rst_s_reg[0], loop_rst};
      lk_cnt_next = lk_cnt_reg;
      if (rst_s_reg[1])
      begin
         lk_cnt_next = '0;
      end
      else if (lk_cnt_reg < LK_W'(LOCK_CYCLES))
      begin
         lk_cnt_next = lk_cnt_reg + LK_W'(1);
      end
      lk_done_next = (lk_cnt_reg == LK_W'(LOCK_CYCLES)) && !rst_s_reg[1];
      lk_tgl_next = ~lk_tgl_reg;
   end

   always_ff @(posedge link_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lk_cnt_reg <= '0;
         lk_done_reg <= 1'b0;
         lk_tgl_reg <= 1'b0;
         rst_s_reg <= 2'b11;
      end
      else
      begin
         lk_cnt_reg <= lk_cnt_next;
         lk_done_reg <= lk_done_next;
         lk_tgl_reg <= lk_tgl_next;
         rst_s_reg <= rst_s_next;
      end
   end


   // ==========================================================
   // system domain: synchronisers, loop reset detection
   // ==========================================================
   logic [2:0] tg_s_reg;
   logic [2:0] tg_s_next;
   logic [1:0] dn_s_reg;
   logic [1:0] dn_s_next;
   logic [1:0] ld_s_reg;
   logic [1:0] ld_s_next;
   logic [1:0] och_s_reg;
   logic [1:0] och_s_next;
   logic [7:0] doff_cnt_reg;
   logic [7:0] doff_cnt_next;
   logic [7:0] kst_cnt_reg;
   logic [7:0] kst_cnt_next;
   logic loop_rst_reg;
   logic loop_rst_next;
   assign loop_rst = loop_rst_reg;

   always_comb
   begin
      tg_s_next = {tg_s_reg[1:0], lk_tgl_reg};
      dn_s_next = {dn_s_reg[0], dll_off_n};
      ld_s_next = {ld_s_reg[0], lk_done_reg};
      och_s_next = {och_s_reg[0], out_clk_high};
      doff_cnt_next = dn_s_reg[1] ? 8'h00 :
         (doff_cnt_reg < 8'(DOFF_CYC) ? doff_cnt_reg + 8'h01 : doff_cnt_reg);
      kst_cnt_next = (tg_s_reg[2] != tg_s_reg[1]) ? 8'h00 :
         (kst_cnt_reg < 8'(KST_CYC) ? kst_cnt_reg + 8'h01 : kst_cnt_reg);
      loop_rst_next = (doff_cnt_reg == 8'(DOFF_CYC))
         || (kst_cnt_reg == 8'(KST_CYC))
         || (loop_rst_reg && ld_s_reg[1]);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tg_s_reg <= 3'h0;
         dn_s_reg <= 2'h3;
         ld_s_reg <= 2'h0;
         och_s_reg <= 2'h0;
         doff_cnt_reg <= 8'h00;
         kst_cnt_reg <= 8'h00;
         loop_rst_reg <= 1'b1;
      end
      else
      begin
         tg_s_reg <= tg_s_next;
         dn_s_reg <= dn_s_next;
         ld_s_reg <= ld_s_next;
         och_s_reg <= och_s_next;
         doff_cnt_reg <= doff_cnt_next;
         kst_cnt_reg <= kst_cnt_next;
         loop_rst_reg <= loop_rst_next;
      end
   end

   // ==========================================================
   // memory, write pipeline, read with forwarding
   // ==========================================================
   logic [W-1:0] mem [0:2*DEPTH-1];
   logic wp_reg;
   logic wp_next;
   logic [ADDR_W-1:0] wa_reg;
   logic [ADDR_W-1:0] wa_next;
   logic [W-1:0] wd1_reg;
   logic [W-1:0] wd1_next;
   logic [W-1:0] wd2_reg;
   logic [W-1:0] wd2_next;
   logic [BYTES-1:0] wm1_reg;
   logic [BYTES-1:0] wm1_next;
   logic [BYTES-1:0] wm2_reg;
   logic [BYTES-1:0] wm2_next;
   logic beat2_reg;
   logic beat2_next;
   logic [W-1:0] b2_reg;
   logic [W-1:0] b2_next;
   logic [W-1:0] rd_data_next;
   logic rd_valid_next;
   logic oe_n_next;
   logic echo_next;
   logic [W-1:0] wr0_data;
   logic [W-1:0] wr1_data;
   logic locked_next;
   logic ref_next;
   bsp_cmd_t cmd;

   always_comb
   begin
      cmd = !rd_req_n ? BSP_READ : (!wr_req_n ? BSP_WRITE : BSP_IDLE);
      wp_next = !wr_req_n;
      wa_next = wr_addr;
      wd1_next = wr_beat1;
      wd2_next = wr_beat2;
      wm1_next = byte_write_mask_n1;
      wm2_next = byte_write_mask_n2;
      beat2_next = 1'b0;
      b2_next = b2_reg;
      rd_data_next = rd_data;
      rd_valid_next = 1'b0;
      echo_next = ~echo_clock;
      if (beat2_reg)
      begin
         rd_data_next = b2_reg;
         rd_valid_next = 1'b1;
      end
      else if (!rd_req_n)
      begin
         rd_data_next = mem[{rd_addr, 1'b0}];
         b2_next = mem[{rd_addr, 1'b1}];
         if (wp_reg && wa_reg == rd_addr)
         begin
            rd_data_next = merge(rd_data_next, wd1_reg, wm1_reg);
            b2_next = merge(b2_next, wd2_reg, wm2_reg);
         end
         rd_valid_next = 1'b1;
         beat2_next = 1'b1;
      end
      if (!och_s_reg[1])
      begin
         echo_next = rd_valid_next;
      end
      oe_n_next = (cmd == BSP_IDLE) && !beat2_reg;
      wr0_data = merge(mem[{wa_reg, 1'b0}], wd1_reg, wm1_reg);
      wr1_data = merge(mem[{wa_reg, 1'b1}], wd2_reg, wm2_reg);
      locked_next = ld_s_reg[1] && !loop_rst_reg;
      ref_next = och_s_reg[1];
   end

   always_ff @(posedge clk_sys)
   begin
      if (wp_reg)
      begin
         mem[{wa_reg, 1'b0}] <= wr0_data;
         mem[{wa_reg, 1'b1}] <= wr1_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wp_reg <= 1'b0;
         wa_reg <= '0;
         wd1_reg <= '0;
         wd2_reg <= '0;
         wm1_reg <= '1;
         wm2_reg <= '1;
         beat2_reg <= 1'b0;
         b2_reg <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
         rd_data_oe_n <= 1'b1;
         echo_clock <= 1'b0;
         dll_locked <= 1'b0;
         ref_from_input <= 1'b0;
      end
      else
      begin
         wp_reg <= wp_next;
         wa_reg <= wa_next;
         wd1_reg <= wd1_next;
         wd2_reg <= wd2_next;
         wm1_reg <= wm1_next;
         wm2_reg <= wm2_next;
         beat2_reg <= beat2_next;
         b2_reg <= b2_next;
         rd_data <= rd_data_next;
         rd_valid <= rd_valid_next;
         rd_data_oe_n <= oe_n_next;
         echo_clock <= echo_next;
         dll_locked <= locked_next;
         ref_from_input <= ref_next;
      end
   end
endmodule

/* test/bsp_chk_chk.sv */
// assertions on the burst-of-two port
`timescale 1ns/1ps
module bsp_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic dll_off_n,
   input wire logic out_clk_high,
   input wire logic rd_req_n,
   input wire logic wr_req_n,
   input wire logic rd_valid,
   input wire logic rd_data_oe_n,
   input wire logic echo_clock,
   input wire logic dll_locked,
   input wire logic ref_from_input
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ==========
   // command steps, reference, echo and lock checks
   sequence s_idle; rd_req_n && wr_req_n && !rd_valid; endsequence
   sequence s_stall;
      $stable(link_clk) [*8] ##1 $stable(link_clk) [*6];
   endsequence
   property p_rd_go; !rd_req_n && !rd_valid |-> ##[1:2] rd_valid; endproperty
   property p_rd_len;
      $rose(rd_valid) |=> rd_valid ##1 (!rd_valid || !$past(rd_req_n));
   endproperty
   property p_oe_on; rd_valid |-> !rd_data_oe_n; endproperty
   property p_oe_off; s_idle ##1 s_idle |=> rd_data_oe_n; endproperty
   property p_ref; $stable(out_clk_high) [*5] |-> ref_from_input == out_clk_high;
   endproperty
   property p_echo; ref_from_input [*3] |-> echo_clock != $past(echo_clock);
   endproperty
   property p_doff; !dll_off_n [*8] |-> !dll_locked; endproperty
   property p_kstop; s_stall |-> !dll_locked; endproperty
   a_rd_go: assert property (p_rd_go) else $error("no read answer");
   a_rd_len: assert property (p_rd_len) else $error("bad beat count");
   a_oe_on: assert property (p_oe_on) else $error("oe off in read");
   a_oe_off: assert property (p_oe_off) else $error("oe on when idle");
   a_ref: assert property (p_ref) else $error("bad reference");
   a_echo: assert property (p_echo) else $error("echo stuck");
   a_doff: assert property (p_doff) else $error("lock kept");
   a_kstop: assert property (p_kstop) else $error("lock kept");
endmodule
bind bsp_port bsp_chk chk_u (
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .link_clk(link_clk),
   .dll_off_n(dll_off_n),
   .out_clk_high(out_clk_high),
   .rd_req_n(rd_req_n),
   .wr_req_n(wr_req_n),
   .rd_valid(rd_valid),
   .rd_data_oe_n(rd_data_oe_n),
   .echo_clock(echo_clock),
   .dll_locked(dll_locked),
   .ref_from_input(ref_from_input)
);

/* test/bsp_host.sv */
// host model making the link clock
`timescale 1ns/1ps
module bsp_host (
   input wire logic run,
   output logic link_clk
);
   initial
   begin
      link_clk = 1'h0;
      #1.3;
      forever
      begin
         #7.5;
         link_clk = run ? ~link_clk : 1'h0;
      end
   end
endmodule

/* test/test_bsp_port.sv */
// self-checking bench for the burst-of-two port
`timescale 1ns/1ps
module test_bsp_port;
   logic clk_sys, rst_b, run, dll_off_n, out_clk_high, rd_req_n, wr_req_n;
   logic link_clk, rd_valid, rd_data_oe_n, echo_clock, dll_locked;
   logic ref_from_input;
   logic [5:0] rd_addr, wr_addr;
   logic [15:0] wr_beat1, wr_beat2, rd_data;
   logic [1:0] byte_write_mask_n1, byte_write_mask_n2;
   logic [15:0] mem [0:127];
   int error_cnt, samples_checked;
   bsp_host host_u (.run(run), .link_clk(link_clk));
   bsp_port #(.LOCK_CYCLES(16)) dut_u (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .link_clk(link_clk),
      .dll_off_n(dll_off_n),
      .out_clk_high(out_clk_high),
      .rd_req_n(rd_req_n),
      .wr_req_n(wr_req_n),
      .rd_addr(rd_addr),
      .wr_addr(wr_addr),
      .wr_beat1(wr_beat1),
      .wr_beat2(wr_beat2),
      .byte_write_mask_n1(byte_write_mask_n1),
      .byte_write_mask_n2(byte_write_mask_n2),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .rd_data_oe_n(rd_data_oe_n),
      .echo_clock(echo_clock),
      .dll_locked(dll_locked),
      .ref_from_input(ref_from_input)
   );
   initial
   begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end
   task chk(string n, logic [15:0] s, logic [15:0] e);
      samples_checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task wrap_up;
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function logic [15:0] mrg(logic [15:0] o, logic [15:0] n,
      logic [1:0] m);
      return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
   endfunction
   task wr(int a, logic [1:0] m1, logic [1:0] m2);
      @(negedge clk_sys);
      rd_req_n = 1'h1;
      wr_req_n = 1'h0;
      wr_addr = a[5:0];
      wr_beat1 = 16'($urandom);
      wr_beat2 = 16'($urandom);
      byte_write_mask_n1 = m1;
      byte_write_mask_n2 = m2;
      mem[2*a] = mrg(mem[2*a], wr_beat1, m1);
      mem[2*a+1] = mrg(mem[2*a+1], wr_beat2, m2);
   endtask
   task rd(int a);
      int i;
      @(negedge clk_sys);
      wr_req_n = 1'h1;
      rd_req_n = 1'h0;
      rd_addr = a[5:0];
      @(negedge clk_sys);
      rd_req_n = 1'h1;
      i = 0;
      while (rd_valid !== 1'h1 && i < 4)
      begin
         @(negedge clk_sys);
         i++;
      end
      chk("lat", 16'(i), 16'h0);
      chk("beat1", rd_data, mem[2*a]);
      if (!out_clk_high)
         chk("echo", 16'(echo_clock), 16'h1);
      @(negedge clk_sys);
      chk("beat2", rd_data, mem[2*a+1]);
      chk("valid", 16'(rd_valid), 16'h1);
      chk("oe_rd", 16'(rd_data_oe_n), 16'h0);
   endtask
   task idle(int n);
      @(negedge clk_sys);
      wr_req_n = 1'h1;
      repeat (n) @(negedge clk_sys);
   endtask
   task lock(logic e);
      int i;
      i = 0;
      while (dll_locked !== e && i < 200)
      begin
         @(negedge clk_sys);
         i++;
      end
      chk("lock", 16'(dll_locked), 16'(e));
   endtask
   task stay_off;
      int h;
      h = 0;
      repeat (40)
      begin
         @(negedge clk_sys);
         h += int'(dll_locked !== 1'h0);
      end
      chk("relock", 16'(h), 16'h0);
   endtask
   initial
   begin
      {rst_b, run, dll_off_n, out_clk_high} = 4'h6;
      {rd_req_n, wr_req_n} = 2'h3;
      {rd_addr, wr_addr, wr_beat1, wr_beat2} = 44'h0;
      {byte_write_mask_n1, byte_write_mask_n2} = 4'hF;
      void'($urandom(73303));
      repeat (3) @(negedge clk_sys);
      rst_b = 1'h1;
      lock(1'h1);
      for (int a = 0; a < 8; a++) wr(a, 2'h0, 2'h0);
      for (int a = 0; a < 8; a++) wr(a, 2'($urandom), 2'($urandom));
      for (int a = 0; a < 8; a++) rd(a);
      for (int k = 0; k < 6; k++)
      begin
         wr(k, 2'($urandom), 2'($urandom));
         rd(k);
      end
      idle(3);
      chk("oe", 16'(rd_data_oe_n), 16'h1);
      out_clk_high = 1'h1;
      idle(6);
      chk("ref", 16'(ref_from_input), 16'h1);
      rd(2);
      out_clk_high = 1'h0;
      dll_off_n = 1'h0;
      idle(10);
      lock(1'h0);
      dll_off_n = 1'h1;
      stay_off;
      lock(1'h1);
      run = 1'h0;
      idle(20);
      lock(1'h0);
      run = 1'h1;
      stay_off;
      lock(1'h1);
      wrap_up;
   end
   initial
   begin
      #20000;
      error_cnt++;
      wrap_up;
   end
endmodule
